/* uart_fifo_control_tb_top.sv */
// Self-checking bench for the FIFO control top.
// Assumes the far-end model stands in for the UART receiver and the USB host.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module uart_fifo_control_tb_top;
    logic clk, rst_n, wr, rd, req, tx_v, tx_rdy, tx_en, rx_en, cust, flow_en, tick, tx_w, rx_w;
    logic rx_v, rx_ir, rx_ordy, tx_ir, tx_ov, rx_ov, done, flow;
    logic [9:0] addr;
    logic [15:0] wdata, rdata;
    logic [7:0] tx_d, rx_d, tx_od, rx_od;
    logic [23:0] baud;
    int bad_count, n_compared, cyc, got;
    ufc_top i_dut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_TX_IN_VALID(tx_v), .I_TX_IN_DATA(tx_d),
        .O_TX_IN_READY(tx_ir), .O_TX_OUT_VALID(tx_ov), .O_TX_OUT_DATA(tx_od),
        .I_TX_OUT_READY(tx_rdy), .I_RX_IN_VALID(rx_v), .I_RX_IN_DATA(rx_d),
        .O_RX_IN_READY(rx_ir), .I_BULK_IN_REQ(req), .O_RX_OUT_VALID(rx_ov),
        .O_RX_OUT_DATA(rx_od), .I_RX_OUT_READY(rx_ordy), .O_BULK_IN_DONE(done),
        .I_TX_ENABLE(tx_en), .I_RX_ENABLE(rx_en), .I_CUSTOM_DRIVER(cust), .I_BAUD_BPS(baud),
        .I_CHAR_TICK(tick), .I_FLOW_ENABLE(flow_en), .O_FLOW_ASSERT(flow), .O_TX_WIDE(tx_w),
        .O_RX_WIDE(rx_w));
    ufc_far_end i_far (.i_clk(clk), .i_rx_ready(rx_ir), .o_rx_valid(rx_v), .o_rx_data(rx_d),
        .o_rx_out_ready(rx_ordy), .o_tick(tick));
    // ****
    // Bus and stream helpers
    // ****
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_reg(input string nm, input logic [9:0] a, input logic [15:0] e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(nm, e, rdata)
        @(posedge clk);
    endtask
    task automatic push_tx(input int n);
        for (int k = 0; k < n; k++) begin
            tx_v <= 1'b1;
            tx_d <= 8'(k);
            do @(negedge clk); while (!tx_ir);
            @(posedge clk);
        end
        tx_v <= 1'b0;
    endtask
    task automatic fill(input bit rx, input int n);
        if (rx) i_far.push(n);
        else push_tx(n);
    endtask
    task automatic set_en(input bit rx, input logic v);
        if (rx) rx_en <= v;
        else tx_en <= v;
        repeat (2) @(posedge clk);
    endtask
    task automatic ask;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask
    // Bounded so a stuck window cannot hang the run
    task automatic collect(output int n);
        n = 0;
        for (int k = 0; k < 400; k++) begin
            @(negedge clk);
            if (rx_ov && rx_ordy) begin
                `CHK("rx byte", 8'(n), rx_od)
                n++;
            end
            if (done) break;
            @(posedge clk);
        end
        @(posedge clk);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        for (int k = 0; k < 9; k++)
            chk_reg("reset value", 10'h040 + 10'(k), k == 7 ? 16'h01C2 : 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_wide;
        wr_reg(ufc_pkg::OFS_TX_WIDE, 16'h0001);
        wr_reg(ufc_pkg::OFS_RX_WIDE, 16'h0001);
        wr_reg(ufc_pkg::OFS_TX_LEVEL, 16'h0155);
        chk_reg("tx wide", ufc_pkg::OFS_TX_WIDE, 16'h0001);
        `CHK("tx wide pin", 1'b1, tx_w)
        chk_reg("rx wide", ufc_pkg::OFS_RX_WIDE, 16'h0001);
        `CHK("rx wide pin", 1'b1, rx_w)
        chk_reg("level write", ufc_pkg::OFS_TX_LEVEL, 16'h0000);
        wr_reg(ufc_pkg::OFS_TX_WIDE, 16'h0000);
        wr_reg(ufc_pkg::OFS_RX_WIDE, 16'h0000);
        @(negedge clk);
        `CHK("wide pins off", 2'h0, {tx_w, rx_w})
        @(posedge clk);
        $display("test wide done");
    endtask
    task automatic t_tx_full;
        push_tx(512);
        chk_reg("tx level full", ufc_pkg::OFS_TX_LEVEL, 16'h0200);
        `CHK("tx refuses", 1'b0, tx_ir)
        wr_reg(ufc_pkg::OFS_TX_FLUSH, 16'h0003);
        chk_reg("tx flushed", ufc_pkg::OFS_TX_LEVEL, 16'h0000);
        push_tx(3);
        tx_rdy <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            `CHK("tx byte", {1'b1, 8'(k)}, {tx_ov, tx_od})
            @(posedge clk);
        end
        tx_rdy <= 1'b0;
        chk_reg("tx drained", ufc_pkg::OFS_TX_LEVEL, 16'h0000);
        $display("test tx full done");
    endtask
    task automatic t_auto(input bit rx);
        logic [9:0] fa, la;
        fa = rx ? ufc_pkg::OFS_RX_FLUSH : ufc_pkg::OFS_TX_FLUSH;
        la = rx ? ufc_pkg::OFS_RX_LEVEL : ufc_pkg::OFS_TX_LEVEL;
        fill(rx, 5);
        set_en(rx, 1'b0);
        chk_reg("close kept", la, 16'h0005);
        set_en(rx, 1'b1);
        chk_reg("open flushed", la, 16'h0000);
        wr_reg(fa, 16'h0004);
        fill(rx, 4);
        set_en(rx, 1'b0);
        chk_reg("close flushed", la, 16'h0000);
        fill(rx, 4);
        set_en(rx, 1'b1);
        chk_reg("open kept", la, 16'h0004);
        wr_reg(fa, 16'h0003);
        chk_reg("manual flush", la, 16'h0000);
        $display("test auto flush done");
    endtask
    task automatic t_flow;
        wr_reg(ufc_pkg::OFS_WATERMARK, 16'h0004);
        flow_en <= 1'b1;
        i_far.push(3);
        @(negedge clk);
        `CHK("flow below mark", 1'b0, flow)
        @(posedge clk);
        i_far.push(1);
        @(negedge clk);
        `CHK("flow at mark", 1'b1, flow)
        @(posedge clk);
        wr_reg(ufc_pkg::OFS_RX_FLUSH, 16'h0003);
        @(negedge clk);
        `CHK("flow after flush", 1'b0, flow)
        @(posedge clk);
        flow_en <= 1'b0;
        wr_reg(ufc_pkg::OFS_WATERMARK, 16'h01C2);
        $display("test flow done");
    endtask
    task automatic t_fast;
        wr_reg(ufc_pkg::OFS_FAST_FWD, 16'h0001);
        i_far.slow = 1'b1;
        i_far.push(3);
        ask;
        collect(got);
        `CHK("fast bytes", 3, got)
        ask;
        collect(got);
        `CHK("empty request", 0, got)
        wr_reg(ufc_pkg::OFS_FAST_FWD, 16'h0000);
        cust <= 1'b0;
        baud <= 24'h009FFF;
        wr_reg(ufc_pkg::OFS_FAST_FWD, 16'h0000);
        chk_reg("fast forced", ufc_pkg::OFS_FAST_FWD, 16'h0001);
        i_far.push(2);
        ask;
        collect(got);
        `CHK("forced bytes", 2, got)
        baud <= 24'h00A000;
        wr_reg(ufc_pkg::OFS_FAST_FWD, 16'h0000);
        chk_reg("fast not forced", ufc_pkg::OFS_FAST_FWD, 16'h0000);
        $display("test fast done");
    endtask
    task automatic t_slow;
        i_far.slow = 1'b0;
        cust <= 1'b1;
        i_far.push(10);
        ask;
        repeat (8) @(negedge clk);
        `CHK("held", 1'b0, rx_ov)
        @(posedge clk);
        i_far.ticks(3);
        collect(got);
        `CHK("timeout bytes", 10, got)
        for (int k = 0; k < 2; k++) begin
            cust <= k[0];
            i_far.push(70);
            ask;
            collect(got);
            `CHK("packet bytes", 63 + k, got)
            chk_reg("packet rest", ufc_pkg::OFS_RX_LEVEL, 16'(7 - k));
            wr_reg(ufc_pkg::OFS_RX_FLUSH, 16'h0003);
        end
        $display("test slow done");
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out;
        end
    end
    initial begin
        {rst_n, wr, rd, req, tx_v, tx_rdy, tx_en, rx_en, flow_en} = 9'h000;
        cust = 1'b1;
        addr = 10'h000;
        wdata = 16'h0000;
        tx_d = 8'h00;
        baud = 24'h01C200;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        @(posedge clk);
        t_reset;
        t_wide;
        t_tx_full;
        t_auto(1'b0);
        t_auto(1'b1);
        t_flow;
        t_fast;
        t_slow;
        close_out;
    end
endmodule

/* ufc_assertions.sv */
// Port checker for the FIFO control top.
// Assumes one clock domain and reserved write bits kept at zero.
`timescale 1ns/1ps
module ufc_assertions (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic [ufc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [ufc_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [ufc_pkg::DATA_W-1:0] O_RDATA,
    input wire logic O_TX_IN_READY,
    input wire logic O_TX_OUT_VALID,
    input wire logic O_RX_IN_READY,
    input wire logic O_RX_OUT_VALID,
    input wire logic I_BULK_IN_REQ,
    input wire logic O_BULK_IN_DONE,
    input wire logic I_TX_ENABLE,
    input wire logic I_RX_ENABLE,
    input wire logic I_CUSTOM_DRIVER,
    input wire logic [23:0] I_BAUD_BPS,
    input wire logic I_FLOW_ENABLE,
    input wire logic O_FLOW_ASSERT,
    input wire logic O_TX_WIDE,
    input wire logic O_RX_WIDE
);
    // ****
    // Shadow of auto bits and of the forwarding state
    // ****
    logic [1:0] txa_ff, rxa_ff;
    logic busy_ff;
    logic slow;
    assign slow = !I_CUSTOM_DRIVER && I_BAUD_BPS < ufc_pkg::SLOW_BAUD_BPS;
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            txa_ff <= 2'h1;
            rxa_ff <= 2'h1;
            busy_ff <= 1'b0;
        end else begin
            if (I_WR && I_ADDR == ufc_pkg::OFS_TX_FLUSH) txa_ff <= I_WDATA[2:1];
            if (I_WR && I_ADDR == ufc_pkg::OFS_RX_FLUSH) rxa_ff <= I_WDATA[2:1];
            if (O_BULK_IN_DONE) busy_ff <= 1'b0;
            else if (I_BULK_IN_REQ) busy_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    a_level_upper: assert property ($past(I_RD) && ($past(I_ADDR) == 10'h041
        || $past(I_ADDR) == 10'h044) |-> O_RDATA[15:10] == 6'h00) else $error("level high bits set");
    a_txflush_clear: assert property (I_WR && I_ADDR == 10'h040 && I_WDATA[0]
        |=> !O_TX_IN_READY && !O_TX_OUT_VALID ##1 !O_TX_OUT_VALID) else $error("tx flush missed");
    a_rxflush_clear: assert property (I_WR && I_ADDR == 10'h043 && I_WDATA[0]
        |=> !O_RX_IN_READY ##1 !O_RX_OUT_VALID) else $error("rx flush missed");
    a_tx_auto: assert property ($rose(I_TX_ENABLE) && txa_ff[0]
        || $fell(I_TX_ENABLE) && txa_ff[1] |-> !O_TX_IN_READY) else $error("tx auto flush missed");
    a_rx_auto: assert property ($rose(I_RX_ENABLE) && rxa_ff[0]
        || $fell(I_RX_ENABLE) && rxa_ff[1] |-> !O_RX_IN_READY) else $error("rx auto flush missed");
    a_txwide_follow: assert property (I_WR && I_ADDR == 10'h042
        |=> O_TX_WIDE == $past(I_WDATA[0])) else $error("tx wide pin wrong");
    a_rxwide_follow: assert property (I_WR && I_ADDR == 10'h045
        |=> O_RX_WIDE == $past(I_WDATA[0])) else $error("rx wide pin wrong");
    a_fast_window: assert property (I_BULK_IN_REQ && !busy_ff && slow && $past(slow)
        && $past(I_RESET_N) |=> O_RX_OUT_VALID || O_BULK_IN_DONE) else $error("window late");
    a_done_close: assert property (O_BULK_IN_DONE |=> !O_RX_OUT_VALID)
        else $error("window open after done");
    a_flow_gate: assert property (!I_FLOW_ENABLE |-> !O_FLOW_ASSERT)
        else $error("flow asserted while disabled");
    c_done: cover property (O_BULK_IN_DONE);
    c_full: cover property ($fell(O_TX_IN_READY) && !I_WR);
    c_flow: cover property ($rose(O_FLOW_ASSERT));
endmodule
bind ufc_top ufc_assertions i_chk (.I_MCLK, .I_RESET_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
    .O_RDATA, .O_TX_IN_READY, .O_TX_OUT_VALID, .O_RX_IN_READY, .O_RX_OUT_VALID, .I_BULK_IN_REQ,
    .O_BULK_IN_DONE, .I_TX_ENABLE, .I_RX_ENABLE, .I_CUSTOM_DRIVER, .I_BAUD_BPS, .I_FLOW_ENABLE,
    .O_FLOW_ASSERT, .O_TX_WIDE, .O_RX_WIDE);

/* ufc_far_end.sv */
// Far-end model: UART receiver filling the receive queue, USB host taking bytes.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module ufc_far_end (
    input wire logic i_clk,
    input wire logic i_rx_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_out_ready,
    output logic o_tick
);
    bit slow;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'hA5;
        o_rx_out_ready = 1'b1;
        o_tick = 1'b0;
    end
    // A slow host takes a byte only every other cycle
    always @(posedge i_clk) o_rx_out_ready <= slow ? !o_rx_out_ready : 1'b1;
    task automatic push(input int n);
        for (int k = 0; k < n; k++) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= 8'(k);
            do @(negedge i_clk); while (!i_rx_ready);
            @(posedge i_clk);
        end
        o_rx_valid <= 1'b0;
        // Released data line must not keep showing the last byte
        o_rx_data <= ~o_rx_data;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            o_tick <= 1'b1;
            @(posedge i_clk);
            o_tick <= 1'b0;
            @(posedge i_clk);
        end
    endtask
endmodule

/* ufc_fifo.sv */
// 512 x 8 byte queue in flip-flops with synchronous flush.
// Assumes the controller drives flush as a one-cycle pulse or a level.
`timescale 1ns/1ps
module ufc_fifo (
    input wire logic i_clk,
    input wire logic i_reset_n,
    ufc_q_if.fifo q
);
    logic [7:0] mem_ff [ufc_pkg::QDEPTH];
    logic [ufc_pkg::PTR_W-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [ufc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic push_fire, pop_fire;

    assign q.push_ready = (cnt_ff != ufc_pkg::CNT_W'(ufc_pkg::QDEPTH)) && !q.flush;
    assign q.pop_valid = (cnt_ff != '0) && !q.flush;
    assign q.pop_data = mem_ff[rd_ff];
    assign q.level = cnt_ff;
    assign push_fire = q.push_valid && q.push_ready;
    assign pop_fire = q.pop_valid && q.pop_ready;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (q.flush) begin
            // Flush drops every byte and wins over traffic in the same cycle
            nxt_wr = '0;
            nxt_rd = '0;
            nxt_cnt = '0;
        end else begin
            if (push_fire) begin
                nxt_wr = wr_ff + 9'h001;
            end
            if (pop_fire) begin
                nxt_rd = rd_ff + 9'h001;
            end
            if (push_fire && !pop_fire) begin
                nxt_cnt = cnt_ff + 10'h001;
            end else if (pop_fire && !push_fire) begin
                nxt_cnt = cnt_ff - 10'h001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; contents are unreachable until written
    always_ff @(posedge i_clk) begin
        if (push_fire && !q.flush) begin
            mem_ff[wr_ff] <= q.push_data;
        end
    end
endmodule

/* ufc_fwd.sv */
// Bulk-in forwarding gate: decides when receive bytes may leave.
// Assumes one pulse per character time on i_char_tick from the baud logic.
`timescale 1ns/1ps
module ufc_fwd (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_bulk_req,
    input wire logic i_fast,
    input wire logic i_cdc_driver,
    input wire logic i_char_tick,
    input wire logic i_pop_fire,
    input wire logic [ufc_pkg::CNT_W-1:0] i_level,
    output logic o_gate,
    output logic o_done
);
    ufc_pkg::ufc_fwd_state_t st_ff, nxt_st;
    logic [ufc_pkg::CNT_W-1:0] sent_ff, nxt_sent, limit;
    logic [1:0] tick_ff, nxt_tick;

    assign limit = i_cdc_driver ? ufc_pkg::PKT_CDC : ufc_pkg::PKT_STD;
    assign o_gate = (st_ff == ufc_pkg::FWD_SEND) && (sent_ff < limit);
    assign o_done = (st_ff == ufc_pkg::FWD_SEND) && ((sent_ff >= limit) || (i_level == '0));

    always_comb begin
        nxt_st = st_ff;
        nxt_sent = sent_ff;
        nxt_tick = tick_ff;
        unique case (st_ff)
            ufc_pkg::FWD_IDLE: begin
                nxt_sent = '0;
                nxt_tick = '0;
                if (i_bulk_req) begin
                    nxt_st = i_fast ? ufc_pkg::FWD_SEND : ufc_pkg::FWD_WAIT;
                end
            end
            ufc_pkg::FWD_WAIT: begin
                if (i_char_tick && (tick_ff != ufc_pkg::TIMEOUT_CHARS)) begin
                    nxt_tick = tick_ff + 2'h1;
                end
                // Hold until fast forwarding, a full packet or three character times
                if (i_fast || (i_level >= limit) || (tick_ff == ufc_pkg::TIMEOUT_CHARS)) begin
                    nxt_st = ufc_pkg::FWD_SEND;
                end
            end
            ufc_pkg::FWD_SEND: begin
                if (o_done) begin
                    nxt_st = ufc_pkg::FWD_IDLE;
                end else if (i_pop_fire) begin
                    nxt_sent = sent_ff + 10'h001;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= ufc_pkg::FWD_IDLE;
            sent_ff <= '0;
            tick_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            sent_ff <= nxt_sent;
            tick_ff <= nxt_tick;
        end
    end
endmodule

/* ufc_pkg.sv */
// Shared constants and types for the UART FIFO control block.
// Assumes a single 50 MHz core clock and a 10-bit word-indexed register port.
package ufc_pkg;
    // ****
    // Register port geometry and offsets
    // ****
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam logic [9:0] OFS_TX_FLUSH = 10'h040;
    localparam logic [9:0] OFS_TX_LEVEL = 10'h041;
    localparam logic [9:0] OFS_TX_WIDE = 10'h042;
    localparam logic [9:0] OFS_RX_FLUSH = 10'h043;
    localparam logic [9:0] OFS_RX_LEVEL = 10'h044;
    localparam logic [9:0] OFS_RX_WIDE = 10'h045;
    localparam logic [9:0] OFS_FAST_FWD = 10'h046;
    localparam logic [9:0] OFS_WATERMARK = 10'h047;

    // ****
    // Field positions and reset values
    // ****
    localparam int BIT_FLUSH_NOW = 0;
    localparam int BIT_AUTO_OPEN = 1;
    localparam int BIT_AUTO_CLOSE = 2;
    localparam int BIT_ENABLE = 0;
    localparam logic RST_AUTO_OPEN = 1'h1;
    localparam logic RST_AUTO_CLOSE = 1'h0;
    localparam logic RST_WIDE = 1'h0;
    localparam logic RST_FAST_FWD = 1'h0;
    localparam logic [9:0] RST_WATERMARK = 10'h1C2;

    // ****
    // Queue sizing and forwarding figures
    // ****
    localparam int QDEPTH = 512;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] PKT_STD = 10'h040;
    localparam logic [CNT_W-1:0] PKT_CDC = 10'h03F;
    localparam logic [23:0] SLOW_BAUD_BPS = 24'h00A000;
    localparam logic [1:0] TIMEOUT_CHARS = 2'h3;

    typedef enum logic [1:0] {FWD_IDLE, FWD_WAIT, FWD_SEND} ufc_fwd_state_t;
endpackage

/* ufc_q_if.sv */
// Byte queue carrier between the control top and one FIFO instance.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ufc_q_if;
    logic push_valid;
    logic [7:0] push_data;
    logic push_ready;
    logic pop_valid;
    logic [7:0] pop_data;
    logic pop_ready;
    logic flush;
    logic [ufc_pkg::CNT_W-1:0] level;
    modport ctl (output push_valid, push_data, pop_ready, flush,
                 input push_ready, pop_valid, pop_data, level);
    modport fifo (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data, level);
endinterface

/* ufc_top.sv */
// Control and status top for the transmit and receive byte queues.
// Assumes synchronous inputs on I_MCLK and a one-cycle strobe register port.
`timescale 1ns/1ps
module ufc_top (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic [ufc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [ufc_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [ufc_pkg::DATA_W-1:0] O_RDATA,
    input wire logic I_TX_IN_VALID,
    input wire logic [7:0] I_TX_IN_DATA,
    output logic O_TX_IN_READY,
    output logic O_TX_OUT_VALID,
    output logic [7:0] O_TX_OUT_DATA,
    input wire logic I_TX_OUT_READY,
    input wire logic I_RX_IN_VALID,
    input wire logic [7:0] I_RX_IN_DATA,
    output logic O_RX_IN_READY,
    input wire logic I_BULK_IN_REQ,
    output logic O_RX_OUT_VALID,
    output logic [7:0] O_RX_OUT_DATA,
    input wire logic I_RX_OUT_READY,
    output logic O_BULK_IN_DONE,
    input wire logic I_TX_ENABLE,
    input wire logic I_RX_ENABLE,
    input wire logic I_CUSTOM_DRIVER,
    input wire logic [23:0] I_BAUD_BPS,
    input wire logic I_CHAR_TICK,
    input wire logic I_FLOW_ENABLE,
    output logic O_FLOW_ASSERT,
    output logic O_TX_WIDE,
    output logic O_RX_WIDE
);
    // ****
    // Queue instances
    // ****
    ufc_q_if txq ();
    ufc_q_if rxq ();

    // Both queues are 512 bytes deep with a 10-bit level
    ufc_fifo u_tx_fifo (
        .i_clk(I_MCLK),
        .i_reset_n(I_RESET_N),
        .q(txq.fifo)
    );

    ufc_fifo u_rx_fifo (
        .i_clk(I_MCLK),
        .i_reset_n(I_RESET_N),
        .q(rxq.fifo)
    );

    // ****
    // Register state
    // ****
    logic tx_auto_open_ff, nxt_tx_auto_open;
    logic tx_auto_close_ff, nxt_tx_auto_close;
    logic tx_flush_now_ff, nxt_tx_flush_now;
    logic rx_auto_open_ff, nxt_rx_auto_open;
    logic rx_auto_close_ff, nxt_rx_auto_close;
    logic rx_flush_now_ff, nxt_rx_flush_now;
    logic tx_wide_ff, nxt_tx_wide;
    logic rx_wide_ff, nxt_rx_wide;
    logic fast_fwd_ff, nxt_fast_fwd;
    logic [ufc_pkg::CNT_W-1:0] watermark_ff, nxt_watermark;
    logic [ufc_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
    logic tx_en_prev_ff, nxt_tx_en_prev;
    logic rx_en_prev_ff, nxt_rx_en_prev;

    logic wr_tx_flush, wr_rx_flush;
    logic tx_auto_flush, rx_auto_flush;
    logic slow_cdc;
    logic fwd_gate, fwd_done;

    assign wr_tx_flush = I_WR && (I_ADDR == ufc_pkg::OFS_TX_FLUSH);
    assign wr_rx_flush = I_WR && (I_ADDR == ufc_pkg::OFS_RX_FLUSH);

    // ****
    // Direction enable edges and automatic flush
    // ****
    // Edge seen against the registered copy; flush is combinational in that cycle
    assign tx_auto_flush = (I_TX_ENABLE && !tx_en_prev_ff && tx_auto_open_ff) ||
                           (!I_TX_ENABLE && tx_en_prev_ff && tx_auto_close_ff);
    assign rx_auto_flush = (I_RX_ENABLE && !rx_en_prev_ff && rx_auto_open_ff) ||
                           (!I_RX_ENABLE && rx_en_prev_ff && rx_auto_close_ff);

    // ****
    // Queue connections
    // ****
    assign txq.push_valid = I_TX_IN_VALID;
    assign txq.push_data = I_TX_IN_DATA;
    assign txq.pop_ready = I_TX_OUT_READY;
    assign txq.flush = tx_flush_now_ff || tx_auto_flush;
    assign O_TX_IN_READY = txq.push_ready;
    assign O_TX_OUT_VALID = txq.pop_valid;
    assign O_TX_OUT_DATA = txq.pop_data;

    assign rxq.push_valid = I_RX_IN_VALID;
    assign rxq.push_data = I_RX_IN_DATA;
    assign rxq.pop_ready = I_RX_OUT_READY && fwd_gate;
    assign rxq.flush = rx_flush_now_ff || rx_auto_flush;
    assign O_RX_IN_READY = rxq.push_ready;
    assign O_RX_OUT_VALID = rxq.pop_valid && fwd_gate;
    assign O_RX_OUT_DATA = rxq.pop_data;
    assign O_BULK_IN_DONE = fwd_done;

    // ****
    // Receive forwarding toward bulk-in
    // ****
    ufc_fwd u_fwd (
        .i_clk(I_MCLK),
        .i_reset_n(I_RESET_N),
        .i_bulk_req(I_BULK_IN_REQ),
        .i_fast(fast_fwd_ff),
        .i_cdc_driver(!I_CUSTOM_DRIVER),
        .i_char_tick(I_CHAR_TICK),
        .i_pop_fire(rxq.pop_valid && rxq.pop_ready),
        .i_level(rxq.level),
        .o_gate(fwd_gate),
        .o_done(fwd_done)
    );

    // ****
    // Flow control and mode outputs
    // ****
    // One comparator of receive level against the watermark feeds the flow output
    assign O_FLOW_ASSERT = I_FLOW_ENABLE && (rxq.level >= watermark_ff);
    assign O_TX_WIDE = tx_wide_ff;
    assign O_RX_WIDE = rx_wide_ff;

    assign slow_cdc = !I_CUSTOM_DRIVER && (I_BAUD_BPS < ufc_pkg::SLOW_BAUD_BPS);

    // ****
    // Register next state
    // ****
    always_comb begin
        nxt_tx_auto_open = tx_auto_open_ff;
        nxt_tx_auto_close = tx_auto_close_ff;
        nxt_rx_auto_open = rx_auto_open_ff;
        nxt_rx_auto_close = rx_auto_close_ff;
        nxt_tx_wide = tx_wide_ff;
        nxt_rx_wide = rx_wide_ff;
        nxt_fast_fwd = fast_fwd_ff;
        nxt_watermark = watermark_ff;
        nxt_tx_en_prev = I_TX_ENABLE;
        nxt_rx_en_prev = I_RX_ENABLE;
        // Flush strobes live for exactly one cycle
        nxt_tx_flush_now = wr_tx_flush && I_WDATA[ufc_pkg::BIT_FLUSH_NOW];
        nxt_rx_flush_now = wr_rx_flush && I_WDATA[ufc_pkg::BIT_FLUSH_NOW];
        if (wr_tx_flush) begin
            nxt_tx_auto_open = I_WDATA[ufc_pkg::BIT_AUTO_OPEN];
            nxt_tx_auto_close = I_WDATA[ufc_pkg::BIT_AUTO_CLOSE];
        end
        if (wr_rx_flush) begin
            nxt_rx_auto_open = I_WDATA[ufc_pkg::BIT_AUTO_OPEN];
            nxt_rx_auto_close = I_WDATA[ufc_pkg::BIT_AUTO_CLOSE];
        end
        if (I_WR && (I_ADDR == ufc_pkg::OFS_TX_WIDE)) begin
            nxt_tx_wide = I_WDATA[ufc_pkg::BIT_ENABLE];
        end
        if (I_WR && (I_ADDR == ufc_pkg::OFS_RX_WIDE)) begin
            nxt_rx_wide = I_WDATA[ufc_pkg::BIT_ENABLE];
        end
        if (I_WR && (I_ADDR == ufc_pkg::OFS_FAST_FWD)) begin
            nxt_fast_fwd = I_WDATA[ufc_pkg::BIT_ENABLE];
        end
        // The hardware set outranks a software clear in the same cycle
        if (slow_cdc) begin
            nxt_fast_fwd = 1'b1;
        end
        if (I_WR && (I_ADDR == ufc_pkg::OFS_WATERMARK)) begin
            nxt_watermark = I_WDATA[ufc_pkg::CNT_W-1:0];
        end
    end

    // ****
    // Read path
    // ****
    // Flush registers are write-only and read as zero, as do unmapped
    // addresses; data appears only in the cycle after the strobe.
    always_comb begin
        nxt_rdata = '0;
        if (I_RD) begin
            unique case (I_ADDR)
                ufc_pkg::OFS_TX_LEVEL: nxt_rdata = {6'h00, txq.level};
                ufc_pkg::OFS_RX_LEVEL: nxt_rdata = {6'h00, rxq.level};
                ufc_pkg::OFS_TX_WIDE: nxt_rdata = {15'h0000, tx_wide_ff};
                ufc_pkg::OFS_RX_WIDE: nxt_rdata = {15'h0000, rx_wide_ff};
                ufc_pkg::OFS_FAST_FWD: nxt_rdata = {15'h0000, fast_fwd_ff};
                ufc_pkg::OFS_WATERMARK: nxt_rdata = {6'h00, watermark_ff};
                default: nxt_rdata = '0;
            endcase
        end
    end

    assign O_RDATA = rdata_ff;

    // ****
    // Registers
    // ****
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tx_auto_open_ff <= ufc_pkg::RST_AUTO_OPEN;
            tx_auto_close_ff <= ufc_pkg::RST_AUTO_CLOSE;
            tx_flush_now_ff <= 1'b0;
            rx_auto_open_ff <= ufc_pkg::RST_AUTO_OPEN;
            rx_auto_close_ff <= ufc_pkg::RST_AUTO_CLOSE;
            rx_flush_now_ff <= 1'b0;
            tx_wide_ff <= ufc_pkg::RST_WIDE;
            rx_wide_ff <= ufc_pkg::RST_WIDE;
            fast_fwd_ff <= ufc_pkg::RST_FAST_FWD;
            watermark_ff <= ufc_pkg::RST_WATERMARK;
            rdata_ff <= '0;
            tx_en_prev_ff <= 1'b0;
            rx_en_prev_ff <= 1'b0;
        end else begin
            tx_auto_open_ff <= nxt_tx_auto_open;
            tx_auto_close_ff <= nxt_tx_auto_close;
            tx_flush_now_ff <= nxt_tx_flush_now;
            rx_auto_open_ff <= nxt_rx_auto_open;
            rx_auto_close_ff <= nxt_rx_auto_close;
            rx_flush_now_ff <= nxt_rx_flush_now;
            tx_wide_ff <= nxt_tx_wide;
            rx_wide_ff <= nxt_rx_wide;
            fast_fwd_ff <= nxt_fast_fwd;
            watermark_ff <= nxt_watermark;
            rdata_ff <= nxt_rdata;
            tx_en_prev_ff <= nxt_tx_en_prev;
            rx_en_prev_ff <= nxt_rx_en_prev;
        end
    end
endmodule
